// ### src/usfbc_pkg.sv
// Package for the serial frame and baud configuration block
// Functional notes
// - Multiprocessor bit enables multiprocessor receive mode
// - Mode field: async, sync, infrared, host SPI
// - Host SPI mode reshapes control register C
// - Parity: off, reserved, even, odd
// - Stop bits one or two, transmitter only
// - Char size 5 to 8 bits, 4-5 reserved
// - Codes 6 and 7: nine bits, byte order
// - SPI bit order: MSB first or LSB
// - SPI phase: sample leading or trailing edge
// - Baud value split over two byte addresses
// - Baud write reloads prescaler immediately
// - Window codes give 32 plus minus 6,5,7,8
// - Sixteen samples per bit, 32 per pair
// - Debug run clear halts in debug break
// - Infrared event input enabled when bit clear
// - Receiver mode 3 is constrained auto-baud
`default_nettype none
package usfbc_pkg;
    localparam logic [7:0] OFF_CTRL_B   = 8'h06;
    localparam logic [7:0] OFF_FRAME    = 8'h07;
    localparam logic [7:0] OFF_BAUD_LO  = 8'h08;
    localparam logic [7:0] OFF_BAUD_HI  = 8'h09;
    localparam logic [7:0] OFF_WINDOW   = 8'h0A;
    localparam logic [7:0] OFF_DEBUG    = 8'h0B;
    localparam logic [7:0] OFF_EVENT    = 8'h0C;
    localparam logic [7:0] RST_CTRL_B   = 8'h00;
    localparam logic [7:0] RST_FRAME    = 8'h03;
    localparam logic [7:0] RST_SPI_VIEW = 8'h00;
    localparam logic [15:0] RST_BAUD    = 16'h0000;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam int POS_MODE   = 6;
    localparam int POS_PARITY = 4;
    localparam int POS_STOP   = 3;
    localparam int POS_ORDER  = 2;
    localparam int POS_PHASE  = 1;
    localparam int POS_RXMODE = 1;
    localparam int POS_WINDOW = 6;
    localparam logic [7:0] SPI_VIEW_MASK = 8'hC6;
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC  = 2'h1;
    localparam logic [1:0] MODE_IR    = 2'h2;
    localparam logic [1:0] MODE_SPI   = 2'h3;
    localparam logic [1:0] RXM_AUTO_CONSTRAINED = 2'h3;
    localparam logic [5:0] SAMPLES_PER_PAIR = 6'h20;
    localparam logic [4:0] SAMPLES_PER_BIT  = 5'h10;
    typedef struct packed {
        logic [1:0] comm_mode_select;
        logic       host_spi_mode;
        logic       infrared_mode;
        logic       parity_enable;
        logic       parity_odd;
        logic       parity_reserved;
        logic       stop_bit_count;
        logic [3:0] data_bits;
        logic       nine_bit_low_first;
        logic       nine_bit_high_first;
        logic       size_reserved;
        logic       spi_bit_order;
        logic       spi_clock_phase;
        logic       multiproc_mode_enable;
        logic       constrained_autobaud_mode;
        logic [5:0] window_min;
        logic [5:0] window_max;
        logic       run_in_debug_halt;
        logic       infrared_event_input_enable;
    } usfbc_cfg_t;
endpackage : usfbc_pkg
`default_nettype wire

// ### src/usfbc_top.sv
// Register file and decoded configuration for the serial frame and baud block
`default_nettype none
module usfbc_top
(
    input  wire logic               SYS_CLK,
    input  wire logic               RESETN,
    input  wire logic               CLK_EN,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [7:0]         PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire logic               DEBUG_HALT,
    output usfbc_pkg::usfbc_cfg_t   CFG,
    output logic      [15:0]        BAUD_VALUE,
    output logic                    BAUD_RELOAD,
    output logic                    PERIPH_RUN
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  ctrl_b_q, ctrl_b_d;
    logic [7:0]  frame_q, frame_d;
    logic [15:0] baud_q, baud_d;
    logic [7:0]  window_q, window_d;
    logic [7:0]  debug_q, debug_d;
    logic [7:0]  event_q, event_d;
    logic        reload_q, reload_d;
    logic [31:0] rdata_q, rdata_d;
    logic        slverr_q, slverr_d;
    logic        ready_q, ready_d;
    logic        halt_s1_q, halt_s2_q, halt_s3_q, halt_q, halt_d;
    logic        fetch, access, wr, rd, mapped;
    logic [1:0]  mode;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == {usfbc_pkg::OFF_CTRL_B[5:0], 2'h0})
                   || (a == {usfbc_pkg::OFF_FRAME[5:0], 2'h0})
                   || (a == {usfbc_pkg::OFF_BAUD_LO[5:0], 2'h0})
                   || (a == {usfbc_pkg::OFF_BAUD_HI[5:0], 2'h0})
                   || (a == {usfbc_pkg::OFF_WINDOW[5:0], 2'h0})
                   || (a == {usfbc_pkg::OFF_DEBUG[5:0], 2'h0})
                   || (a == {usfbc_pkg::OFF_EVENT[5:0], 2'h0});
    endfunction : addr_mapped

    function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
        hit = (a == {idx[5:0], 2'h0});
    endfunction : hit

    // Printed offsets are not word aligned, so each is an index of a word
    // One wait state: the first access cycle fetches, the second answers
    assign fetch  = PSEL && PENABLE && !ready_q && CLK_EN;
    assign access = PSEL && PENABLE && ready_q && CLK_EN;
    assign wr     = access && PWRITE;
    assign rd     = fetch && !PWRITE;
    assign mapped = addr_mapped(PADDR);
    assign mode   = frame_q[usfbc_pkg::POS_MODE +: 2];
    // A frozen block still ends the transfer, with no effect
    assign PREADY = ready_q || !CLK_EN;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_comb
    begin
        ctrl_b_d = ctrl_b_q;
        frame_d  = frame_q;
        baud_d   = baud_q;
        window_d = window_q;
        debug_d  = debug_q;
        event_d  = event_q;
        reload_d = 1'b0;
        if (wr)
        begin
            if (hit(PADDR, usfbc_pkg::OFF_CTRL_B))
                ctrl_b_d = PWDATA[7:0];
            if (hit(PADDR, usfbc_pkg::OFF_FRAME))
            begin
                // New mode decides which layout the rest of the byte uses
                if (PWDATA[usfbc_pkg::POS_MODE +: 2] == usfbc_pkg::MODE_SPI)
                    frame_d = PWDATA[7:0] & usfbc_pkg::SPI_VIEW_MASK;
                else
                    frame_d = PWDATA[7:0];
            end
            if (hit(PADDR, usfbc_pkg::OFF_BAUD_LO))
            begin
                baud_d[7:0] = PWDATA[7:0];
                reload_d    = 1'b1;
            end
            if (hit(PADDR, usfbc_pkg::OFF_BAUD_HI))
            begin
                baud_d[15:8] = PWDATA[7:0];
                reload_d     = 1'b1;
            end
            if (hit(PADDR, usfbc_pkg::OFF_WINDOW))
                window_d = {PWDATA[7:6], 6'h00};
            if (hit(PADDR, usfbc_pkg::OFF_DEBUG))
                debug_d = {7'h00, PWDATA[0]};
            if (hit(PADDR, usfbc_pkg::OFF_EVENT))
                event_d = {7'h00, PWDATA[0]};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctrl_b_q <= usfbc_pkg::RST_CTRL_B;
            frame_q  <= usfbc_pkg::RST_FRAME;
            baud_q   <= usfbc_pkg::RST_BAUD;
            window_q <= usfbc_pkg::RST_BYTE;
            debug_q  <= usfbc_pkg::RST_BYTE;
            event_q  <= usfbc_pkg::RST_BYTE;
            reload_q <= 1'b0;
        end
        else if (CLK_EN)
        begin
            ctrl_b_q <= ctrl_b_d;
            frame_q  <= frame_d;
            baud_q   <= baud_d;
            window_q <= window_d;
            debug_q  <= debug_d;
            event_q  <= event_d;
            reload_q <= reload_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and error answer
    always_comb
    begin
        rdata_d  = rdata_q;
        slverr_d = slverr_q;
        ready_d  = PSEL && PENABLE && !ready_q;
        if (fetch)
        begin
            rdata_d  = 32'h0000_0000;
            slverr_d = !mapped;
        end
        if (rd)
        begin
            if (hit(PADDR, usfbc_pkg::OFF_CTRL_B))
                rdata_d = {24'h00_0000, ctrl_b_q};
            if (hit(PADDR, usfbc_pkg::OFF_FRAME))
                rdata_d = {24'h00_0000, frame_q};
            if (hit(PADDR, usfbc_pkg::OFF_BAUD_LO))
                rdata_d = {24'h00_0000, baud_q[7:0]};
            if (hit(PADDR, usfbc_pkg::OFF_BAUD_HI))
                rdata_d = {24'h00_0000, baud_q[15:8]};
            if (hit(PADDR, usfbc_pkg::OFF_WINDOW))
                rdata_d = {24'h00_0000, window_q};
            if (hit(PADDR, usfbc_pkg::OFF_DEBUG))
                rdata_d = {24'h00_0000, debug_q};
            if (hit(PADDR, usfbc_pkg::OFF_EVENT))
                rdata_d = {24'h00_0000, event_q};
        end
    end

    // Answer stands from flip-flops for the whole ready cycle
    always_comb
    begin
        PRDATA  = rdata_q;
        PSLVERR = ready_q && slverr_q;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
            ready_q  <= 1'b0;
        end
        else if (CLK_EN)
        begin
            rdata_q  <= rdata_d;
            slverr_q <= slverr_d;
            ready_q  <= ready_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug halt input comes from another domain: three stages, agree on two
    always_comb
    begin
        halt_d = halt_q;
        if (halt_s2_q == halt_s3_q)
            halt_d = halt_s3_q;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            halt_s1_q <= 1'b0;
            halt_s2_q <= 1'b0;
            halt_s3_q <= 1'b0;
            halt_q    <= 1'b0;
        end
        else if (CLK_EN)
        begin
            halt_s1_q <= DEBUG_HALT;
            halt_s2_q <= halt_s1_q;
            halt_s3_q <= halt_s2_q;
            halt_q    <= halt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded configuration, all from registers
    always_comb
    begin
        CFG = '0;
        CFG.comm_mode_select  = mode;
        CFG.host_spi_mode     = (mode == usfbc_pkg::MODE_SPI);
        CFG.infrared_mode     = (mode == usfbc_pkg::MODE_IR);
        CFG.multiproc_mode_enable = ctrl_b_q[0];
        CFG.constrained_autobaud_mode =
            (ctrl_b_q[usfbc_pkg::POS_RXMODE +: 2] == usfbc_pkg::RXM_AUTO_CONSTRAINED);
        if (mode == usfbc_pkg::MODE_SPI)
        begin
            CFG.spi_bit_order   = frame_q[usfbc_pkg::POS_ORDER];
            CFG.spi_clock_phase = frame_q[usfbc_pkg::POS_PHASE];
            CFG.data_bits       = 4'h8;
        end
        else
        begin
            case (frame_q[usfbc_pkg::POS_PARITY +: 2])
                2'h0: CFG.parity_enable = 1'b0;
                2'h1: CFG.parity_reserved = 1'b1;
                2'h2: CFG.parity_enable = 1'b1;
                2'h3:
                begin
                    CFG.parity_enable = 1'b1;
                    CFG.parity_odd    = 1'b1;
                end
                default: CFG.parity_enable = 1'b0;
            endcase
            CFG.stop_bit_count = frame_q[usfbc_pkg::POS_STOP];
            case (frame_q[2:0])
                3'h0: CFG.data_bits = 4'h5;
                3'h1: CFG.data_bits = 4'h6;
                3'h2: CFG.data_bits = 4'h7;
                3'h3: CFG.data_bits = 4'h8;
                3'h6:
                begin
                    CFG.data_bits          = 4'h9;
                    CFG.nine_bit_low_first = 1'b1;
                end
                3'h7:
                begin
                    CFG.data_bits           = 4'h9;
                    CFG.nine_bit_high_first = 1'b1;
                end
                default: CFG.size_reserved = 1'b1;
            endcase
        end
        // Bounds on sample count across a bit pair of 32
        case (window_q[usfbc_pkg::POS_WINDOW +: 2])
            2'h0:
            begin
                CFG.window_min = usfbc_pkg::SAMPLES_PER_PAIR - 6'h06;
                CFG.window_max = usfbc_pkg::SAMPLES_PER_PAIR + 6'h06;
            end
            2'h1:
            begin
                CFG.window_min = usfbc_pkg::SAMPLES_PER_PAIR - 6'h05;
                CFG.window_max = usfbc_pkg::SAMPLES_PER_PAIR + 6'h05;
            end
            2'h2:
            begin
                CFG.window_min = usfbc_pkg::SAMPLES_PER_PAIR - 6'h07;
                CFG.window_max = usfbc_pkg::SAMPLES_PER_PAIR + 6'h07;
            end
            default:
            begin
                CFG.window_min = usfbc_pkg::SAMPLES_PER_PAIR - 6'h08;
                CFG.window_max = usfbc_pkg::SAMPLES_PER_PAIR + 6'h08;
            end
        endcase
        CFG.run_in_debug_halt = debug_q[0];
        CFG.infrared_event_input_enable = !event_q[0];
    end

    assign BAUD_VALUE  = baud_q;
    assign BAUD_RELOAD = reload_q;
    // Halted peripheral also ignores events: consumers gate on this
    assign PERIPH_RUN  = debug_q[0] || !halt_q;

    ////////////////////////////////////////////////////////////////////////////
    property p_multiproc_mode_enable;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (wr && hit(PADDR, usfbc_pkg::OFF_CTRL_B)) |=> (CFG.multiproc_mode_enable == $past(PWDATA[0]));
    endproperty
    a_multiproc_mode_enable: assert property (p_multiproc_mode_enable) else $error("multiproc enable mismatch");

    property p_spi_view;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (mode == usfbc_pkg::MODE_SPI) |-> ((frame_q & ~usfbc_pkg::SPI_VIEW_MASK) == 8'h00);
    endproperty
    a_spi_view: assert property (p_spi_view) else $error("spi view holds stray bits");

    property p_reload;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (CLK_EN && wr && (hit(PADDR, usfbc_pkg::OFF_BAUD_LO) || hit(PADDR, usfbc_pkg::OFF_BAUD_HI)))
            |=> BAUD_RELOAD;
    endproperty
    a_reload: assert property (p_reload) else $error("baud write did not reload");

    property p_baud_lo;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (CLK_EN && wr && hit(PADDR, usfbc_pkg::OFF_BAUD_LO)) |=> (BAUD_VALUE[7:0] == $past(PWDATA[7:0]));
    endproperty
    a_baud_lo: assert property (p_baud_lo) else $error("baud low byte not stored");

    property p_parity;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (!CFG.host_spi_mode && frame_q[5:4] == 2'h3) |-> (CFG.parity_enable && CFG.parity_odd);
    endproperty
    a_parity: assert property (p_parity) else $error("odd parity not decoded");

    property p_nine;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (!CFG.host_spi_mode && frame_q[2:1] == 2'h3) |-> (CFG.data_bits == 4'h9);
    endproperty
    a_nine: assert property (p_nine) else $error("nine bit size not decoded");

    property p_window;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (window_q[7:6] == 2'h3) |-> (CFG.window_min == 6'h18 && CFG.window_max == 6'h28);
    endproperty
    a_window: assert property (p_window) else $error("window bounds wrong");

    property p_halt;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (CLK_EN && !debug_q[0] && halt_s2_q && halt_s3_q && !(wr && hit(PADDR, usfbc_pkg::OFF_DEBUG)))
            |=> !PERIPH_RUN;
    endproperty
    a_halt: assert property (p_halt) else $error("peripheral runs in debug halt");

    property p_event;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (wr && hit(PADDR, usfbc_pkg::OFF_EVENT)) |=> (CFG.infrared_event_input_enable == !$past(PWDATA[0]));
    endproperty
    a_event: assert property (p_event) else $error("event enable polarity wrong");

    property p_baud_hi;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (wr && hit(PADDR, usfbc_pkg::OFF_BAUD_HI)) |=> (BAUD_VALUE[15:8] == $past(PWDATA[7:0]));
    endproperty
    a_baud_hi: assert property (p_baud_hi) else $error("baud high byte not stored");

    property p_no_reload;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (CLK_EN && !(wr && (hit(PADDR, usfbc_pkg::OFF_BAUD_LO) || hit(PADDR, usfbc_pkg::OFF_BAUD_HI))))
            |=> !BAUD_RELOAD;
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("reload without baud write");

    property p_size_low;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (!CFG.host_spi_mode && !frame_q[2]) |-> (CFG.data_bits == 4'h5 + {2'h0, frame_q[1:0]});
    endproperty
    a_size_low: assert property (p_size_low) else $error("short size not decoded");

    property p_spi_order;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (wr && hit(PADDR, usfbc_pkg::OFF_FRAME) && (PWDATA[usfbc_pkg::POS_MODE +: 2] == usfbc_pkg::MODE_SPI))
            |=> (CFG.host_spi_mode && CFG.spi_bit_order == $past(PWDATA[usfbc_pkg::POS_ORDER]));
    endproperty
    a_spi_order: assert property (p_spi_order) else $error("spi bit order not taken");

    property p_rd_frame;
        @(posedge SYS_CLK) disable iff (!RESETN)
        (rd && hit(PADDR, usfbc_pkg::OFF_FRAME)) |=> (PRDATA == {24'h00_0000, $past(frame_q)});
    endproperty
    a_rd_frame: assert property (p_rd_frame) else $error("frame read back wrong");
endmodule : usfbc_top
`default_nettype wire

// ### sim/usfbc_far_model.sv
// Far-side model: debug halt source and baud reload observer
`default_nettype none
module usfbc_far_model
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       halt_req,
    input  wire logic       baud_reload,
    output logic            debug_halt,
    output logic      [7:0] reload_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // Halt comes from another domain in the real part; the design resyncs it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            debug_halt   <= 1'b0;
            reload_count <= 8'h00;
        end
        else
        begin
            debug_halt <= halt_req;
            if (baud_reload)
                reload_count <= reload_count + 8'h01;
        end
    end
endmodule : usfbc_far_model
`default_nettype wire

// ### sim/test_usart_frame_and_baud_config.sv
// Self-checking bench for the frame and baud configuration block
`default_nettype none
module test_usart_frame_and_baud_config;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 sys_clk = 1'b0;
    logic                 resetn, clk_en, psel, penable, pwrite, halt_req;
    logic                 pready, pslverr, debug_halt, baud_reload, periph_run, err;
    logic [7:0]           paddr, reload_count, v;
    logic [31:0]          pwdata, prdata, rd;
    logic [15:0]          baud_value;
    logic [1:0]           m, p;
    logic [2:0]           sz;
    usfbc_pkg::usfbc_cfg_t cfg;
    int                   errors = 0;
    int                   comparisons = 0;
    logic [5:0]           wmin [4] = '{6'h1A, 6'h1B, 6'h19, 6'h18};
    logic [5:0]           wmax [4] = '{6'h26, 6'h25, 6'h27, 6'h28};
    logic [7:0]           zregs [6];

    always #4 sys_clk = ~sys_clk;

    usfbc_top u_dut (.SYS_CLK(sys_clk), .RESETN(resetn), .CLK_EN(clk_en), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DEBUG_HALT(debug_halt), .CFG(cfg),
        .BAUD_VALUE(baud_value), .BAUD_RELOAD(baud_reload), .PERIPH_RUN(periph_run));

    usfbc_far_model u_far (.clk(sys_clk), .rst_n(resetn), .halt_req(halt_req),
        .baud_reload(baud_reload), .debug_halt(debug_halt), .reload_count(reload_count));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Register index to byte address: one aligned word per register
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Wait states are the slave's choice; the wait ends on PREADY, with no cycle limit, so only the watchdog ends a hung wait
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
        @(negedge sys_clk);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdc

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        resetn = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; halt_req = 1'b0;
        zregs = '{usfbc_pkg::OFF_CTRL_B, usfbc_pkg::OFF_BAUD_LO, usfbc_pkg::OFF_BAUD_HI,
                  usfbc_pkg::OFF_WINDOW, usfbc_pkg::OFF_DEBUG, usfbc_pkg::OFF_EVENT};
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        rdc(usfbc_pkg::OFF_FRAME, 32'h3);
        foreach (zregs[k])
            rdc(zregs[k], 32'h0);
        chk(cfg.infrared_event_input_enable, 32'h1);
        // Every mode, parity and size code that software may use
        for (int i = 0; i < 6; i++)
        begin
            m = 2'(i % 3);
            p = (m == 2'h0) ? 2'h0 : m + 2'h1;
            sz = (i < 4) ? 3'(i) : 3'(i + 2);
            v = {m, p, sz[2] ^ sz[0], sz};
            wr(usfbc_pkg::OFF_FRAME, {24'h0, v});
            rdc(usfbc_pkg::OFF_FRAME, {24'h0, v});
            chk(cfg.comm_mode_select, m);
            chk(cfg.infrared_mode, m == 2'h2);
            chk(cfg.parity_enable, p[1]);
            chk(cfg.parity_reserved, p == 2'h1);
            if (p[1])
                chk(cfg.parity_odd, p[0]);
            chk(cfg.stop_bit_count, v[3]);
            chk(cfg.size_reserved, sz == 3'h4 || sz == 3'h5);
            chk(cfg.nine_bit_low_first, sz == 3'h6);
            chk(cfg.nine_bit_high_first, sz == 3'h7);
            if (sz < 3'h4)
                chk(cfg.data_bits, sz + 32'h5);
            else if (sz > 3'h5)
                chk(cfg.data_bits, 32'h9);
        end
        wr(usfbc_pkg::OFF_FRAME, 32'hFF);
        rdc(usfbc_pkg::OFF_FRAME, 32'hC6);
        chk(cfg.host_spi_mode, 32'h1);
        chk(cfg.spi_bit_order, 32'h1);
        chk(cfg.spi_clock_phase, 32'h1);
        wr(usfbc_pkg::OFF_FRAME, 32'hC0);
        chk(cfg.spi_bit_order, 32'h0);
        chk(cfg.spi_clock_phase, 32'h0);
        wr(usfbc_pkg::OFF_FRAME, 32'h2B);
        rdc(usfbc_pkg::OFF_FRAME, 32'h2B);
        chk(cfg.host_spi_mode, 32'h0);
        // Baud halves land independently, each reloading the prescaler
        wr(usfbc_pkg::OFF_BAUD_LO, 32'h5A);
        chk(baud_value, 32'h005A);
        wr(usfbc_pkg::OFF_BAUD_HI, 32'hA5);
        chk(baud_value, 32'hA55A);
        rdc(usfbc_pkg::OFF_BAUD_HI, 32'hA5);
        rdc(usfbc_pkg::OFF_BAUD_LO, 32'h5A);
        chk(reload_count, 32'h2);
        wr(usfbc_pkg::OFF_CTRL_B, 32'h07);
        chk(cfg.constrained_autobaud_mode, 32'h1);
        chk(cfg.multiproc_mode_enable, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            wr(usfbc_pkg::OFF_WINDOW, {24'h0, 2'(i), 6'h00});
            chk(cfg.window_min, wmin[i]);
            chk(cfg.window_max, wmax[i]);
        end
        wr(usfbc_pkg::OFF_CTRL_B, 32'h02);
        chk(cfg.constrained_autobaud_mode, 32'h0);
        chk(cfg.multiproc_mode_enable, 32'h0);
        @(posedge sys_clk);
        halt_req <= 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(periph_run, 32'h0);
        wr(usfbc_pkg::OFF_DEBUG, 32'h1);
        chk(periph_run, 32'h1);
        wr(usfbc_pkg::OFF_EVENT, 32'h1);
        chk(cfg.infrared_event_input_enable, 32'h0);
        // Unmapped word: refused both ways
        apb(1'b1, 8'h0F, 32'hFF);
        chk(err, 32'h1);
        apb(1'b0, 8'h0F, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        // Gated clock enable must block the store
        clk_en <= 1'b0;
        apb(1'b1, usfbc_pkg::OFF_FRAME, 32'h00);
        clk_en <= 1'b1;
        rdc(usfbc_pkg::OFF_FRAME, 32'h2B);
        report_and_stop();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        #50us;
        errors++;
        report_and_stop();
    end
endmodule : test_usart_frame_and_baud_config
`default_nettype wire
